// >>> inc/mipm_defines.svh
// offsets, field positions, reset values and timing counts of the irq and phy management block
`ifndef MIPM_DEFINES_SVH
`define MIPM_DEFINES_SVH

// register byte offsets
`define MIPM_OFF_EVENT_FLAGS 12'h024
`define MIPM_OFF_ENABLE_PORT 12'h028
`define MIPM_OFF_DISABLE_PORT 12'h02C
`define MIPM_OFF_MASK_STATE 12'h030
`define MIPM_OFF_MGMT_FRAME 12'h034
`define MIPM_OFF_PAUSE_TIME 12'h038

// event flag positions
`define MIPM_BIT_MGMT_DONE 0
`define MIPM_BIT_RX_COMPLETE 1
`define MIPM_BIT_RX_OWNED 2
`define MIPM_BIT_TX_OWNED 3
`define MIPM_BIT_TX_UNDERRUN 4
`define MIPM_BIT_RETRY_LIMIT 5
`define MIPM_BIT_TX_EXHAUSTED 6
`define MIPM_BIT_TX_COMPLETE 7
`define MIPM_BIT_RX_OVERRUN 10
`define MIPM_BIT_BUS_ERROR 11
`define MIPM_BIT_PAUSE_RX 12
`define MIPM_BIT_PAUSE_ZERO 13
`define MIPM_IRQ_IMPL 32'h0000_3CFF
`define MIPM_MASK_RESET 32'h0000_3CFF

// management frame fields
`define MIPM_SOF_HI 31
`define MIPM_SOF_LO 30
`define MIPM_OP_HI 29
`define MIPM_OP_LO 28
`define MIPM_PHYSEL_HI 27
`define MIPM_PHYSEL_LO 23
`define MIPM_REGSEL_HI 22
`define MIPM_REGSEL_LO 18
`define MIPM_TURN_HI 17
`define MIPM_TURN_LO 16
`define MIPM_DATA_HI 15
`define MIPM_DATA_LO 0
`define MIPM_SOF_VALID 2'b01
`define MIPM_OP_READ 2'b10
`define MIPM_OP_WRITE 2'b01
`define MIPM_MGMT_RESET 32'h0000_0000

// serial frame timing: preamble bits, bit of release on a read, data start
`define MIPM_PREAMBLE_BITS 7'd32
`define MIPM_FRAME_BITS 7'd64
`define MIPM_READ_RELEASE 7'd46
`define MIPM_READ_DATA 7'd48
`define MIPM_MDC_HALF 32

// pause timing
`define MIPM_PAUSE_BIT_TIMES 512
`define MIPM_PAUSE_WIDTH 16
`define MIPM_PAUSE_RESET 16'h0000

`endif

// >>> inc/mipm_pkg.sv
// types shared by the irq and phy management block
package mipm_pkg;
  typedef enum logic [1:0] {
    MIPM_IDLE = 2'b00,
    MIPM_SHIFT = 2'b01,
    MIPM_FINISH = 2'b10
  } mipm_mgmt_state_t;

  typedef enum logic [1:0] {
    MIPM_APB_IDLE = 2'b00,
    MIPM_APB_ACCESS = 2'b01
  } mipm_apb_state_t;
endpackage

// >>> hdl/mipm_mgmt_shift.sv
// serial management frame shifter toward the phy
`timescale 1ns/1ps
`include "mipm_defines.svh"
module mipm_mgmt_shift #(
  parameter int MDC_HALF = `MIPM_MDC_HALF
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic start, // one-cycle pulse, begin a frame
  input wire logic [31:0] frame, // assembled frame word
  input wire logic isRead, // frame is a phy read
  input wire logic mdioIn, // management data pin level
  output logic mdc, // management clock
  output logic mdioOut, // management data driven level
  output logic mdioOeN, // low while driving the data pin
  output logic busy, // frame in flight
  output logic donePulse, // one-cycle pulse at frame end
  output logic [15:0] readData // data captured from the phy
);
  mipm_pkg::mipm_mgmt_state_t state_q;
  logic [63:0] shift_q;
  logic [6:0] edges_q;
  logic [15:0] divCnt_q;
  logic tick;
  logic read_q;

  assign tick = (divCnt_q == 16'(MDC_HALF - 1));
  // the done cycle counts as busy: a store then would lose to the read-data update
  assign busy = (state_q != mipm_pkg::MIPM_IDLE) || donePulse;

  always_ff @(posedge mclk)
  begin
    if (sys_rst || state_q == mipm_pkg::MIPM_IDLE || tick)
      divCnt_q <= 16'h0000;
    else
      divCnt_q <= divCnt_q + 16'h0001;
  end

  always_ff @(posedge mclk)
  begin
    donePulse <= 1'b0;
    if (sys_rst)
    begin
      state_q <= mipm_pkg::MIPM_IDLE;
      shift_q <= 64'h0000_0000_0000_0000;
      edges_q <= 7'h00;
      mdc <= 1'b0;
      mdioOut <= 1'b1;
      mdioOeN <= 1'b1;
      read_q <= 1'b0;
      readData <= 16'h0000;
    end
    else
    begin
      unique case (state_q)
        mipm_pkg::MIPM_IDLE:
        begin
          mdc <= 1'b0;
          mdioOeN <= 1'b1;
          if (start)
          begin
            // preamble of ones ahead of the frame proper
            shift_q <= {32'hFFFF_FFFF, frame};
            read_q <= isRead;
            edges_q <= 7'h00;
            mdioOut <= 1'b1;
            mdioOeN <= 1'b0;
            state_q <= mipm_pkg::MIPM_SHIFT;
          end
        end
        mipm_pkg::MIPM_SHIFT:
        begin
          if (tick)
          begin
            mdc <= ~mdc;
            if (!mdc)
            begin
              // rising edge: the phy samples, we sample read data
              if (read_q && edges_q >= `MIPM_READ_DATA)
                readData <= {readData[14:0], mdioIn};
              edges_q <= edges_q + 7'h01;
              if (edges_q == `MIPM_FRAME_BITS - 7'h01)
                state_q <= mipm_pkg::MIPM_FINISH;
            end
            else
            begin
              // falling edge: present the next bit
              shift_q <= {shift_q[62:0], 1'b0};
              mdioOut <= shift_q[62];
              mdioOeN <= read_q && edges_q >= `MIPM_READ_RELEASE;
            end
          end
        end
        mipm_pkg::MIPM_FINISH:
        begin
          if (tick)
          begin
            mdc <= 1'b0;
            mdioOeN <= 1'b1;
            donePulse <= 1'b1;
            state_q <= mipm_pkg::MIPM_IDLE;
          end
        end
        default:
          state_q <= mipm_pkg::MIPM_IDLE;
      endcase
    end
  end
endmodule

// >>> hdl/mipm_pause_timer.sv
// pause time counter, one step per 512 bit times
`timescale 1ns/1ps
`include "mipm_defines.svh"
module mipm_pause_timer #(
  parameter int WIDTH = `MIPM_PAUSE_WIDTH,
  parameter int BIT_TIMES = `MIPM_PAUSE_BIT_TIMES
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic bitTick, // one pulse per bit time
  input wire logic load, // load a new pause duration
  input wire logic [WIDTH-1:0] loadValue, // duration to load
  output logic [WIDTH-1:0] count, // current pause count
  output logic zeroPulse // one-cycle pulse on reaching zero
);
  logic [9:0] slot_q;

  always_ff @(posedge mclk)
  begin
    zeroPulse <= 1'b0;
    if (sys_rst)
    begin
      count <= WIDTH'(0);
      slot_q <= 10'h000;
    end
    else if (load)
    begin
      count <= loadValue;
      slot_q <= 10'h000;
    end
    else if (bitTick && count != WIDTH'(0))
    begin
      if (slot_q == 10'(BIT_TIMES - 1))
      begin
        slot_q <= 10'h000;
        count <= count - WIDTH'(1);
        zeroPulse <= (count == WIDTH'(1));
      end
      else
        slot_q <= slot_q + 10'h001;
    end
  end
endmodule

// >>> hdl/mipm_top.sv
// interrupt flags, mask ports, phy management frame and pause timer behind apb
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "mipm_defines.svh"
module mipm_top #(
  parameter int MDC_HALF = `MIPM_MDC_HALF,
  parameter int PAUSE_BIT_TIMES = `MIPM_PAUSE_BIT_TIMES
) (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic rxComplete, // pulse: received frame stored
  input wire logic rxOwnedFetch, // pulse: rx descriptor already owned
  input wire logic txOwnedFetch, // pulse: tx descriptor already owned
  input wire logic txUnderrun, // pulse: tx dma late, bus error or owned mid-frame
  input wire logic txQueueWrite, // pulse: new tx queue pointer written
  input wire logic retryLimit, // pulse: retry limit exceeded
  input wire logic txExhausted, // pulse: tx buffers ran out mid-frame
  input wire logic txComplete, // pulse: frame fully sent
  input wire logic rxOverrun, // pulse: rx overrun status became set
  input wire logic busError, // pulse: dma saw a bus error response
  input wire logic pauseReceived, // pulse: valid pause frame arrived
  input wire logic [15:0] pauseQuanta, // pause duration of that frame
  input wire logic bitTick, // one pulse per line bit time
  input wire logic mdioIn, // management data pin level
  output logic mdc, // management clock to the phy
  output logic mdioOut, // management data driven level
  output logic mdioOeN, // low while driving management data
  output logic pausing, // pause count is non-zero
  output logic irq // interrupt request, active high
);
  logic [31:0] flags_q;
  logic [31:0] mask_q;
  logic [31:0] mgmt_q;
  logic [31:0] events;
  logic [31:0] readClear;
  logic [31:0] rdValue;
  logic [15:0] pauseCount;
  logic [15:0] mgmtReadData;
  logic mgmtBusy;
  logic mgmtDone;
  logic pauseZero;
  logic mgmtStart;
  logic pauseLoad;
  logic [15:0] pauseLoadValue;
  logic setupPhase;
  logic accessDone;
  logic wrDone;
  logic rdDone;
  logic [11:0] addr_q;
  logic mapped;

  // address match on a word, used for every register
  function automatic logic regHit(input logic [11:0] a, input logic [11:0] off);
    regHit = (a[11:2] == off[11:2]);
  endfunction

  function automatic logic frameValid(input logic [31:0] f);
    frameValid = (f[`MIPM_SOF_HI:`MIPM_SOF_LO] == `MIPM_SOF_VALID)
      && (f[`MIPM_OP_HI:`MIPM_OP_LO] == `MIPM_OP_READ
      || f[`MIPM_OP_HI:`MIPM_OP_LO] == `MIPM_OP_WRITE);
  endfunction

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = regHit(a, `MIPM_OFF_EVENT_FLAGS) || regHit(a, `MIPM_OFF_ENABLE_PORT)
      || regHit(a, `MIPM_OFF_DISABLE_PORT) || regHit(a, `MIPM_OFF_MASK_STATE)
      || regHit(a, `MIPM_OFF_MGMT_FRAME) || regHit(a, `MIPM_OFF_PAUSE_TIME);
  endfunction

  // apb handshake: ready rises in the access phase, no wait states
  assign setupPhase = psel && !penable && !pready;
  assign accessDone = psel && penable && pready;
  assign wrDone = accessDone && pwrite && mapped;
  assign rdDone = accessDone && !pwrite && mapped;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      mapped <= 1'b0;
      addr_q <= 12'h000;
    end
    else if (setupPhase)
    begin
      pready <= 1'b1;
      pslverr <= !isMapped(paddr);
      mapped <= isMapped(paddr);
      addr_q <= paddr;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      mapped <= 1'b0;
    end
  end

  // read data is captured in the setup phase; write-only ports read as zero
  always_comb
  begin
    rdValue = 32'h0000_0000;
    if (regHit(paddr, `MIPM_OFF_EVENT_FLAGS))
      rdValue = flags_q;
    else if (regHit(paddr, `MIPM_OFF_MASK_STATE))
      rdValue = mask_q;
    else if (regHit(paddr, `MIPM_OFF_MGMT_FRAME))
      rdValue = mgmt_q;
    else if (regHit(paddr, `MIPM_OFF_PAUSE_TIME))
      rdValue = {16'h0000, pauseCount};
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (setupPhase && !pwrite)
      prdata <= rdValue;
    else
      prdata <= 32'h0000_0000;
  end

  // only the bits returned to software are cleared; a late event survives
  assign readClear = (rdDone && regHit(addr_q, `MIPM_OFF_EVENT_FLAGS)) ? prdata
    : 32'h0000_0000;

  always_comb
  begin
    events = 32'h0000_0000;
    events[`MIPM_BIT_MGMT_DONE] = mgmtDone;
    events[`MIPM_BIT_RX_COMPLETE] = rxComplete;
    events[`MIPM_BIT_RX_OWNED] = rxOwnedFetch;
    events[`MIPM_BIT_TX_OWNED] = txOwnedFetch;
    events[`MIPM_BIT_TX_UNDERRUN] = txUnderrun
      || txQueueWrite;
    events[`MIPM_BIT_RETRY_LIMIT] = retryLimit;
    events[`MIPM_BIT_TX_EXHAUSTED] = txExhausted;
    events[`MIPM_BIT_TX_COMPLETE] = txComplete;
    events[`MIPM_BIT_RX_OVERRUN] = rxOverrun;
    events[`MIPM_BIT_BUS_ERROR] = busError;
    events[`MIPM_BIT_PAUSE_RX] = pauseReceived;
    events[`MIPM_BIT_PAUSE_ZERO] = pauseZero;
  end

  // set wins over the clear on read
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      flags_q <= 32'h0000_0000;
    else
      flags_q <= ((flags_q & ~readClear) | events) & `MIPM_IRQ_IMPL;
  end

  // mask: enable port clears mask bits, disable port sets them
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      mask_q <= `MIPM_MASK_RESET;
    else if (wrDone && regHit(addr_q, `MIPM_OFF_ENABLE_PORT))
      mask_q <= mask_q & ~(pwdata & `MIPM_IRQ_IMPL);
    else if (wrDone && regHit(addr_q, `MIPM_OFF_DISABLE_PORT))
      mask_q <= mask_q | (pwdata & `MIPM_IRQ_IMPL);
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(flags_q & ~mask_q);
  end

  // management frame register; a write during a frame is ignored so the
  // frame on the wire matches what software reads back when all four byte strobes are set
  assign mgmtStart = wrDone && regHit(addr_q, `MIPM_OFF_MGMT_FRAME) && !mgmtBusy
    && frameValid(pwdata);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      mgmt_q <= `MIPM_MGMT_RESET;
    else if (mgmtDone && mgmt_q[`MIPM_OP_HI:`MIPM_OP_LO] == `MIPM_OP_READ)
      mgmt_q[`MIPM_DATA_HI:`MIPM_DATA_LO] <= mgmtReadData;
    else if (wrDone && regHit(addr_q, `MIPM_OFF_MGMT_FRAME) && !mgmtBusy)
    begin
      // each strobed byte stored as written, turnaround included
      if (pstrb[0])
        mgmt_q[7:0] <= pwdata[7:0];
      if (pstrb[1])
        mgmt_q[15:8] <= pwdata[15:8];
      if (pstrb[2])
        mgmt_q[23:16] <= pwdata[23:16];
      if (pstrb[3])
        mgmt_q[31:24] <= pwdata[31:24];
    end
  end

  mipm_mgmt_shift #(
    .MDC_HALF(MDC_HALF)
  ) u_mgmt (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(mgmtStart),
    .frame(pwdata),
    .isRead(pwdata[`MIPM_OP_HI:`MIPM_OP_LO] == `MIPM_OP_READ),
    .mdioIn(mdioIn),
    .mdc(mdc),
    .mdioOut(mdioOut),
    .mdioOeN(mdioOeN),
    .busy(mgmtBusy),
    .donePulse(mgmtDone),
    .readData(mgmtReadData)
  );

  // pause counter: software write or received pause frame loads it
  always_comb
  begin
    pauseLoad = 1'b0;
    pauseLoadValue = pauseQuanta;
    if (wrDone && regHit(addr_q, `MIPM_OFF_PAUSE_TIME))
    begin
      pauseLoad = 1'b1;
      pauseLoadValue = pwdata[15:0];
    end
    else if (pauseReceived)
      pauseLoad = 1'b1;
  end

  mipm_pause_timer #(
    .WIDTH(`MIPM_PAUSE_WIDTH),
    .BIT_TIMES(PAUSE_BIT_TIMES)
  ) u_pause (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .bitTick(bitTick),
    .load(pauseLoad),
    .loadValue(pauseLoadValue),
    .count(pauseCount),
    .zeroPulse(pauseZero)
  );

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      pausing <= 1'b0;
    else
      pausing <= (pauseCount != 16'h0000);
  end
endmodule

// >>> bench/mipm_top_sva.sv
// port-level checker for the irq and phy management block
`timescale 1ns/1ps
module mipm_top_sva #(
  parameter int MDC_HALF = 2
) (
  input wire logic mclk, // clock
  input wire logic sys_rst, // reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic pauseReceived, // pause frame pulse
  input wire logic [15:0] pauseQuanta, // pause duration
  input wire logic mdc, // management clock
  input wire logic mdioOut, // management data out
  input wire logic mdioOeN, // management drive enable
  input wire logic pausing // pause active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [7:0] hiCnt;
  wire logic mapped = (paddr[11:2] >= 10'h009) && (paddr[11:2] <= 10'h00E);
  wire logic ptWrite = psel && penable && pwrite && (paddr[11:2] == 10'h00E);
  sequence sSetup;
    psel && !penable;
  endsequence
  // high-phase length of mdc, cleared whenever mdc is low
  always_ff @(posedge mclk)
    if (sys_rst || !mdc)
      hiCnt <= 8'h00;
    else
      hiCnt <= hiCnt + 8'h01;
  chk_ready_next: assert property (sSetup |=> pready) else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready) else $error("ready held twice");
  chk_err_unmapped: assert property (sSetup ##0 !mapped |=> pslverr) else $error("no error");
  chk_err_mapped: assert property (sSetup ##0 mapped |=> !pslverr) else $error("false error");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0000_0000) else $error("data idle");
  chk_wo_zero: assert property (sSetup ##0 (!pwrite && (paddr[11:3] == 9'h005))
    |=> prdata == 32'h0000_0000) else $error("write-only port read non-zero");
  chk_pause_load: assert property (pauseReceived && pauseQuanta != 16'h0000 && !ptWrite
    |-> ##2 pausing) else $error("pause not loaded");
  chk_mdc_high: assert property (mdc |-> hiCnt < MDC_HALF) else $error("mdc high too long");
  chk_mdc_fall: assert property ($fell(mdc) |-> $past(hiCnt) == MDC_HALF - 1)
    else $error("mdc high too short");
  chk_bit_on_fall: assert property (!mdioOeN && !$past(mdioOeN) && $changed(mdioOut)
    |-> $fell(mdc)) else $error("data moved off mdc fall");
endmodule
bind mipm_top mipm_top_sva #(.MDC_HALF(MDC_HALF)) i_sva (.mclk, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .pauseReceived, .pauseQuanta, .mdc, .mdioOut,
  .mdioOeN, .pausing);

// >>> bench/mipm_phy_model.sv
// behavioural phy at the far end of the management link
`timescale 1ns/1ps
module mipm_phy_model #(
  parameter logic [4:0] PHY_SEL = 5'h03 // address this phy answers to
) (
  input wire logic mdc, // management clock
  input wire logic mdioLine, // resolved data line
  output logic phyOeN, // low while this phy drives
  output logic phyBit // level driven by this phy
);
  logic [6:0] cnt = 7'h40;
  logic [31:0] fr;
  logic [15:0] regs [32];
  logic [15:0] rdData;
  logic rdHit = 1'b0;
  wire logic [31:0] full = {fr[30:0], mdioLine};
  initial phyOeN = 1'b1;
  always @(posedge mdc)
  begin
    cnt <= (cnt == 7'h40) ? 7'h01 : cnt + 7'h01;
    fr <= full;
    if (cnt == 7'h3F && full[31:28] == 4'h5 && full[27:23] == PHY_SEL)
      regs[full[22:18]] <= full[15:0];
  end
  // drives only the second turnaround bit and the data of a read aimed at this phy; idle frames leave the line
  always @(negedge mdc)
  begin
    if (cnt == 7'h2E)
    begin
      rdHit <= (fr[13:10] == 4'h6) && (fr[9:5] == PHY_SEL);
      rdData <= regs[fr[4:0]];
    end
    phyOeN <= !(rdHit && cnt >= 7'h2F && cnt <= 7'h3F);
    phyBit <= (cnt == 7'h2F) ? 1'b0 : rdData[4'(7'h3F - cnt)];
  end
endmodule

// >>> bench/tb.sv
// self-checking bench for the irq and phy management block
`timescale 1ns/1ps
`include "mipm_defines.svh"
module tb;
  localparam int MDC_HALF = 2;
  localparam int PAUSE_BIT_TIMES = 4;
  localparam logic [4:0] PHY_SEL = 5'h03;
  typedef struct packed {logic [10:0] ev; logic [31:0] flag; logic en;} mipm_row_t;
  logic mclk, sys_rst, psel, penable, pwrite, bitTick, tickOn, err;
  logic pready, pslverr, mdc, mdioOut, mdioOeN, pausing, irq, phyOeN, phyBit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, wf, rf;
  logic [10:0] ev;
  logic [15:0] pauseQuanta;
  int errorCnt, nCompared;
  mipm_row_t rows [11] = '{'{11'h001, 32'h0000_0002, 1'b1}, '{11'h002, 32'h0000_0004, 1'b0},
    '{11'h004, 32'h0000_0008, 1'b1}, '{11'h008, 32'h0000_0010, 1'b0},
    '{11'h010, 32'h0000_0010, 1'b1}, '{11'h020, 32'h0000_0020, 1'b0},
    '{11'h040, 32'h0000_0040, 1'b1}, '{11'h080, 32'h0000_0080, 1'b0},
    '{11'h100, 32'h0000_0400, 1'b1}, '{11'h200, 32'h0000_0800, 1'b0},
    '{11'h400, 32'h0000_1000, 1'b1}};
  // the management line has a pull-up, so nobody driving reads as one
  wire logic mdioLine = !mdioOeN ? mdioOut : (!phyOeN ? phyBit : 1'b1);
  mipm_top #(.MDC_HALF(MDC_HALF), .PAUSE_BIT_TIMES(PAUSE_BIT_TIMES)) i_dut (.mclk, .sys_rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
    .rxComplete(ev[0]), .rxOwnedFetch(ev[1]), .txOwnedFetch(ev[2]), .txUnderrun(ev[3]),
    .txQueueWrite(ev[4]), .retryLimit(ev[5]), .txExhausted(ev[6]), .txComplete(ev[7]),
    .rxOverrun(ev[8]), .busError(ev[9]), .pauseReceived(ev[10]), .pauseQuanta, .bitTick,
    .mdioIn(mdioLine), .mdc, .mdioOut, .mdioOeN, .pausing, .irq);
  mipm_phy_model #(.PHY_SEL(PHY_SEL)) i_phy (.mdc, .mdioLine, .phyOeN, .phyBit);
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) bitTick <= tickOn && !bitTick;
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      errorCnt++;
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      errorCnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(nm, exp, rd);
  endtask
  task waitDone();
    int k;
    k = 0;
    do
    begin
      apb(1'b0, `MIPM_OFF_EVENT_FLAGS, 32'h0000_0000);
      k++;
    end
    while (rd[0] !== 1'b1 && k < 200);
    check("mgmt done", 32'h0000_0001, {31'h0, rd[0]});
  endtask
  task reportAndStop();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk);
    errorCnt++;
    reportAndStop();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, ev, pauseQuanta, tickOn} = '0;
    sys_rst = 1'b1;
    errorCnt = 0;
    nCompared = 0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rdchk("mask reset", `MIPM_OFF_MASK_STATE, 32'h0000_3CFF);
    rdchk("flags reset", `MIPM_OFF_EVENT_FLAGS, 32'h0000_0000);
    rdchk("frame reset", `MIPM_OFF_MGMT_FRAME, 32'h0000_0000);
    rdchk("enable port", `MIPM_OFF_ENABLE_PORT, 32'h0000_0000);
    rdchk("disable port", `MIPM_OFF_DISABLE_PORT, 32'h0000_0000);
    apb(1'b0, 12'h040, 32'h0000_0000);
    check("unmapped error", 32'h0000_0001, {31'h0, err});
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b1, `MIPM_OFF_ENABLE_PORT, rows[i].en ? rows[i].flag : 32'h0000_0000);
      rdchk("mask", `MIPM_OFF_MASK_STATE, 32'h0000_3CFF & ~(rows[i].en ? rows[i].flag : 32'h0));
      ev <= rows[i].ev;
      @(posedge mclk) ev <= '0;
      @(posedge mclk) #1;
      check("irq", {31'h0, rows[i].en}, {31'h0, irq});
      rdchk("flags", `MIPM_OFF_EVENT_FLAGS, rows[i].flag);
      rdchk("flags cleared", `MIPM_OFF_EVENT_FLAGS, 32'h0000_0000);
      check("irq cleared", 32'h0000_0000, {31'h0, irq});
      apb(1'b1, `MIPM_OFF_DISABLE_PORT, 32'h0000_3CFF);
    end
    rdchk("mask all", `MIPM_OFF_MASK_STATE, 32'h0000_3CFF);
    // an event held through the clearing read must survive it
    ev <= 11'h080;
    apb(1'b0, `MIPM_OFF_EVENT_FLAGS, 32'h0000_0000);
    ev <= '0;
    check("flags held", 32'h0000_0080, rd);
    rdchk("flags set wins", `MIPM_OFF_EVENT_FLAGS, 32'h0000_0080);
    rdchk("flags gone", `MIPM_OFF_EVENT_FLAGS, 32'h0000_0000);
    apb(1'b1, `MIPM_OFF_PAUSE_TIME, 32'h0000_0003);
    rdchk("pause load", `MIPM_OFF_PAUSE_TIME, 32'h0000_0003);
    check("pausing", 32'h0000_0001, {31'h0, pausing});
    tickOn <= 1'b1;
    repeat (40) @(posedge mclk);
    rdchk("pause zero", `MIPM_OFF_EVENT_FLAGS, 32'h0000_2000);
    rdchk("pause end", `MIPM_OFF_PAUSE_TIME, 32'h0000_0000);
    ev <= 11'h400;
    pauseQuanta <= 16'h0002;
    @(posedge mclk) ev <= '0;
    repeat (30) @(posedge mclk);
    rdchk("pause frame", `MIPM_OFF_EVENT_FLAGS, 32'h0000_3000);
    tickOn <= 1'b0;
    // mid-run reset drops a pending interrupt and restores the mask
    apb(1'b1, `MIPM_OFF_ENABLE_PORT, 32'h0000_0080);
    ev <= 11'h080;
    @(posedge mclk) ev <= '0;
    repeat (2) @(posedge mclk);
    check("irq before reset", 32'h0000_0001, {31'h0, irq});
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    check("irq after reset", 32'h0000_0000, {31'h0, irq});
    rdchk("mask after reset", `MIPM_OFF_MASK_STATE, 32'h0000_3CFF);
    rdchk("flags after reset", `MIPM_OFF_EVENT_FLAGS, 32'h0000_0000);
    wf = {2'b01, 2'b01, PHY_SEL, 5'h05, 2'b10, 16'hA5C3};
    rf = {2'b01, 2'b10, PHY_SEL, 5'h05, 2'b10, 16'h0000};
    apb(1'b1, `MIPM_OFF_MGMT_FRAME, wf);
    waitDone();
    apb(1'b1, `MIPM_OFF_MGMT_FRAME, rf);
    apb(1'b1, `MIPM_OFF_MGMT_FRAME, {wf[31:16], 16'h1111});
    waitDone();
    rdchk("phy read", `MIPM_OFF_MGMT_FRAME, {rf[31:16], 16'hA5C3});
    rf[23] = ~rf[23];
    apb(1'b1, `MIPM_OFF_MGMT_FRAME, rf);
    waitDone();
    rdchk("absent phy", `MIPM_OFF_MGMT_FRAME, {rf[31:16], 16'hFFFF});
    apb(1'b1, `MIPM_OFF_MGMT_FRAME, {2'b00, wf[29:0]});
    apb(1'b1, `MIPM_OFF_MGMT_FRAME, {4'h7, wf[27:0]});
    repeat (300) @(posedge mclk);
    rdchk("invalid op", `MIPM_OFF_EVENT_FLAGS, 32'h0000_0000);
    rdchk("invalid stored", `MIPM_OFF_MGMT_FRAME, {4'h7, wf[27:0]});
    reportAndStop();
  end
endmodule
